// [src/trs_sequencer.sv]
// Functional notes
// RULE1: While the on/off input is low all three converters stay disabled.
// RULE2: Start-up begins when on/off goes high, with the order taken from the order-select strap.
// RULE3: Strap at ground enables 5 V, then 3.3 V, then the adjustable rail.
// RULE4: Strap at the logic supply enables 3.3 V, then 5 V, then the adjustable rail.
// RULE5: Strap at the reference uses the 3.3 V first order and enters high-impedance error-detect mode.
// RULE6: The second rail starts soft-start only once the first rail reports in tolerance.
// RULE7: The adjustable rail starts soft-start only once the second rail reports in tolerance.
// RULE8: Power-good stays low until both bucks are in tolerance and 32,000 cycles passed since the second rail settled.
// RULE9: The power-good timer counts oscillator cycles and power-good stays low throughout the count.
// RULE10: With the 5 V feedback above 4.5 V the linear regulator is off and logic runs from the 5 V output.
// RULE11: On/off going low clears the counter, drives power-good low and returns the sequencer to idle.
`timescale 1ns/10ps
`default_nettype none

module trs_sequencer
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic on_off,
   input wire logic [1:0] order_select_strap,
   input wire trs_pkg::trs_rails_type rail_in_tol,
   input wire logic five_volt_feedback_above,
   output trs_pkg::trs_rails_type rail_enable,
   output logic power_good,
   output logic power_good_oe,
   output logic error_detect_hiz,
   output logic internal_logic_supply_from_5v
);

   // Two-flop synchronisers for pin inputs
   logic on_s1_r, on_s2_r;
   logic fb_s1_r, fb_s2_r;
   trs_pkg::trs_rails_type tol_s1_r, tol_s2_r;
   logic [1:0] strap_s1_r, strap_s2_r;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         on_s1_r <= 1'b0;
         on_s2_r <= 1'b0;
         fb_s1_r <= 1'b0;
         fb_s2_r <= 1'b0;
         tol_s1_r <= '0;
         tol_s2_r <= '0;
         strap_s1_r <= 2'h0;
         strap_s2_r <= 2'h0;
      end
      else if (clk_en)
      begin
         on_s1_r <= on_off;
         on_s2_r <= on_s1_r;
         fb_s1_r <= five_volt_feedback_above;
         fb_s2_r <= fb_s1_r;
         tol_s1_r <= rail_in_tol;
         tol_s2_r <= tol_s1_r;
         strap_s1_r <= order_select_strap;
         strap_s2_r <= strap_s1_r;
      end
   end

   // Sequencer state, latched strap and power-good timer
   trs_pkg::trs_state_type state_r, state_nxt;
   logic [1:0] strap_r;
   logic [trs_pkg::PG_CNT_W-1:0] cnt_r, cnt_nxt;
   logic pg_r, pg_nxt;
   trs_pkg::trs_rails_type en_r, en_nxt;
   logic hiz_r;
   logic ldo_off_r;

   // Strap seen live while idle, so the first enable never uses a stale order
   wire logic [1:0] strap_cur = (state_r == trs_pkg::TRS_IDLE) ? strap_s2_r : strap_r; // [RULE2]

   // Order decode: ground strap puts 5 V first, otherwise 3.3 V first
   wire logic five_first = (strap_cur == trs_pkg::TRS_STRAP_GND); // [RULE3] [RULE4] [RULE5]
   wire logic first_tol = five_first ? tol_s2_r.v5 : tol_s2_r.v33;
   wire logic second_tol = five_first ? tol_s2_r.v33 : tol_s2_r.v5;
   wire logic bucks_tol = tol_s2_r.v5 & tol_s2_r.v33;
   wire logic cnt_done = (cnt_r == trs_pkg::PG_CNT_LAST);

   // Next-state and enable logic
   always_comb
   begin
      state_nxt = state_r;
      en_nxt = en_r;
      cnt_nxt = cnt_r;
      pg_nxt = pg_r;
      unique case (state_r)
         trs_pkg::TRS_IDLE:
         begin
            en_nxt = '0; // [RULE1]
            cnt_nxt = trs_pkg::PG_CNT_ZERO;
            pg_nxt = 1'b0;
            if (on_s2_r) // [RULE2]
            begin
               state_nxt = trs_pkg::TRS_FIRST;
               en_nxt.v5 = five_first;
               en_nxt.v33 = !five_first;
            end
         end
         trs_pkg::TRS_FIRST:
            if (first_tol) // [RULE6]
            begin
               state_nxt = trs_pkg::TRS_SECOND;
               en_nxt.v5 = 1'b1;
               en_nxt.v33 = 1'b1;
            end
         trs_pkg::TRS_SECOND:
            if (second_tol) // [RULE7]
            begin
               state_nxt = trs_pkg::TRS_THIRD;
               en_nxt.adj = 1'b1;
               cnt_nxt = trs_pkg::PG_CNT_ZERO;
            end
         trs_pkg::TRS_THIRD:
            if (!bucks_tol)
               cnt_nxt = trs_pkg::PG_CNT_ZERO; // [RULE8]
            else if (cnt_done)
            begin
               state_nxt = trs_pkg::TRS_DONE;
               pg_nxt = 1'b1; // [RULE8]
            end
            else
               cnt_nxt = cnt_r + 15'h0001; // [RULE9]
         trs_pkg::TRS_DONE:
            pg_nxt = bucks_tol;
      endcase
      if (!on_s2_r)
      begin
         state_nxt = trs_pkg::TRS_IDLE; // [RULE11]
         en_nxt = '0; // [RULE1]
         cnt_nxt = trs_pkg::PG_CNT_ZERO; // [RULE11]
         pg_nxt = 1'b0; // [RULE11]
      end
   end

   // State registers
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_r <= trs_pkg::TRS_IDLE;
         en_r <= '0;
         cnt_r <= trs_pkg::PG_CNT_ZERO;
         pg_r <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         en_r <= en_nxt;
         cnt_r <= cnt_nxt;
         pg_r <= pg_nxt;
      end
   end

   // Strap capture at start, error-detect mode and supply switch-over
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         strap_r <= 2'h0;
         hiz_r <= 1'b0;
         ldo_off_r <= 1'b0;
      end
      else if (clk_en)
      begin
         if (state_r == trs_pkg::TRS_IDLE)
            strap_r <= strap_s2_r; // [RULE2]
         hiz_r <= on_s2_r && (strap_cur == trs_pkg::TRS_STRAP_REF); // [RULE5]
         ldo_off_r <= fb_s2_r; // [RULE10]
      end
   end

   assign rail_enable = en_r;
   assign power_good = 1'b0;
   assign power_good_oe = !pg_r; // Open drain: pull low until good
   assign error_detect_hiz = hiz_r;
   assign internal_logic_supply_from_5v = ldo_off_r;

   // Checks
   sequence s_second_up;
      state_r == trs_pkg::TRS_SECOND && second_tol && on_s2_r && clk_en;
   endsequence

   sequence s_adj_start;
      $rose(en_r.adj);
   endsequence

   off_all_disabled_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE1]
      !on_s2_r && clk_en |=> en_r == '0)
      else $error("rails enabled while off");
   start_from_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
      state_r == trs_pkg::TRS_IDLE && on_s2_r && clk_en |=> (en_r.v5 ^ en_r.v33) && !en_r.adj)
      else $error("start did not enable exactly one buck");
   gnd_order_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
      state_r == trs_pkg::TRS_FIRST && five_first |-> en_r.v5 && !en_r.v33)
      else $error("ground strap order wrong");
   logic_order_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
      state_r == trs_pkg::TRS_FIRST && !five_first |-> en_r.v33 && !en_r.v5)
      else $error("logic supply strap order wrong");
   ref_hiz_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
      hiz_r && $past(clk_en) |-> $past(strap_cur == trs_pkg::TRS_STRAP_REF) && $past(on_s2_r))
      else $error("error-detect mode without reference strap");
   second_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
      $rose(en_r.v5 & en_r.v33) |-> $past(first_tol))
      else $error("second rail started early");
   third_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
      s_second_up |=> en_r.adj)
      else $error("adjustable rail did not start");
   adj_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
      s_adj_start |-> $past(state_r == trs_pkg::TRS_SECOND && second_tol))
      else $error("adjustable rail started early");
   pg_release_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
      $rose(pg_r) |-> $past(cnt_done) && $past(bucks_tol))
      else $error("power-good released early");
   pg_low_count_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE9]
      state_r == trs_pkg::TRS_THIRD |-> !pg_r)
      else $error("power-good high during count");
   ldo_switch_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE10]
      clk_en |=> ldo_off_r == $past(fb_s2_r))
      else $error("supply switch-over not following feedback");
   off_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE11]
      !on_s2_r && clk_en |=> state_r == trs_pkg::TRS_IDLE && cnt_r == trs_pkg::PG_CNT_ZERO && !pg_r)
      else $error("off did not return to idle");

endmodule : trs_sequencer

`default_nettype wire

// [include/trs_pkg.sv]
package trs_pkg;

   // Power-good delay in oscillator cycles
   localparam int unsigned PG_DELAY_CYCLES = 32000;
   localparam int unsigned PG_CNT_W = 15;
   localparam logic [PG_CNT_W-1:0] PG_CNT_LAST = 15'(PG_DELAY_CYCLES - 1);
   localparam logic [PG_CNT_W-1:0] PG_CNT_ZERO = 15'h0000;

   // Strap decode levels
   typedef enum logic [1:0]
   {
      TRS_STRAP_GND = 2'h0,
      TRS_STRAP_LOGIC = 2'h1,
      TRS_STRAP_REF = 2'h2
   } trs_strap_type;

   // Sequencer states
   typedef enum logic [2:0]
   {
      TRS_IDLE,
      TRS_FIRST,
      TRS_SECOND,
      TRS_THIRD,
      TRS_DONE
   } trs_state_type;

   // Per-rail flags, one bit per converter
   typedef struct packed
   {
      logic adj;
      logic v33;
      logic v5;
   } trs_rails_type;

endpackage : trs_pkg

// [bench/trs_rail_model.sv]
`timescale 1ns/10ps
`default_nettype none

// Converter plant: each rail reaches tolerance a while after its enable
module trs_rail_model
#(
   parameter int DLY = 20
)
(
   input wire logic core_clk,
   input wire trs_pkg::trs_rails_type rail_enable,
   input wire logic power_good,
   input wire logic power_good_oe,
   output trs_pkg::trs_rails_type rail_in_tol,
   output logic pg_line
);
   int cnt [3];

   // Pull-up holds the reset line high once released
   assign pg_line = power_good_oe ? power_good : 1'b1;

   // Soft-start ramp per rail, tolerance lost at once on disable
   always @(posedge core_clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         cnt[i] = rail_enable[i] ? cnt[i] + 1 : 0;
         rail_in_tol[i] <= cnt[i] > DLY;
      end
   end
endmodule : trs_rail_model

`default_nettype wire

// [bench/tb_trs_sequencer.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_trs_sequencer;
   logic core_clk = 0;
   logic rst_n = 0;
   logic clk_en = 1;
   logic on_off = 0;
   logic [1:0] strap = 0;
   logic fb_above = 0;
   trs_pkg::trs_rails_type en;
   trs_pkg::trs_rails_type tol;
   logic pg, pg_oe, hiz, ldo_off, pg_line;
   int bad_count = 0;
   int n_tests = 0;
   int seed = 86243;

   trs_sequencer dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .on_off(on_off),
      .order_select_strap(strap), .rail_in_tol(tol), .five_volt_feedback_above(fb_above),
      .rail_enable(en), .power_good(pg), .power_good_oe(pg_oe), .error_detect_hiz(hiz),
      .internal_logic_supply_from_5v(ldo_off));
   trs_rail_model rail_u (.core_clk(core_clk), .rail_enable(en), .power_good(pg),
      .power_good_oe(pg_oe), .rail_in_tol(tol), .pg_line(pg_line));

   // Clock, 10 ns period
   always #5 core_clk = ~core_clk;

   function automatic int xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   // Wait for the enables to move, bounded
   task automatic step(output int n);
      trs_pkg::trs_rails_type prev;
      prev = en;
      n = 0;
      while (en === prev && n < 200)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask : step

   // One start-up, model order held in a queue
   task automatic run_seq(input logic [1:0] s, input bit full);
      int ord[$];
      int n;
      strap = s;
      ord = {(s == 2'h0) ? 1 : 2, 3, 7};
      on_off = 1;
      foreach (ord[i])
      begin
         step(n);
         chk(en, ord[i]);
         if (i > 0)
            chk(n > 20, 1);
      end
      chk(hiz, s == 2'h2);
      if (full)
      begin
         n = 0;
         while (pg_oe === 1'b1 && n < 33000)
         begin
            @(negedge core_clk);
            n++;
         end
         chk(n >= 31997 && n <= 32003, 1);
         chk(pg_line, 1);
      end
      on_off = 0;
      repeat (4) @(negedge core_clk);
      chk({en, pg_oe, pg_line, hiz}, 6'h04);
      $display("Start-up with strap %0d done", s);
   endtask : run_seq

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Watchdog sized for two full power-good delays
   initial
   begin
      repeat (70000) @(posedge core_clk);
      bad_count++;
      end_sim();
   end

   initial
   begin
      repeat (20) @(negedge core_clk);
      rst_n = 1;
      repeat (5) @(negedge core_clk);
      chk({en, pg_oe}, 4'h1);
      // Clock enable low must freeze the synchronisers and the sequencer
      clk_en = 0;
      on_off = 1;
      repeat (10) @(negedge core_clk);
      chk(en, 0);
      on_off = 0;
      repeat (3) @(negedge core_clk);
      clk_en = 1;
      repeat (4) @(negedge core_clk);
      chk({en, pg_oe}, 4'h1);
      $display("Reset and clock enable freeze done");
      repeat (8)
      begin
         fb_above = 1'(xs());
         repeat (4) @(negedge core_clk);
         chk(ldo_off, fb_above);
      end
      $display("Logic supply switching done");
      run_seq(2'h0, 1);
      run_seq(2'h1, 0);
      run_seq(2'h3, 0);
      run_seq(2'h2, 1);
      end_sim();
   end
endmodule : tb_trs_sequencer

`default_nettype wire
